/* common/epx_regs.vh */
// Register map, reset values and field layout of the eight-pin port
// ==========================================================
// Notes on behaviour
// R1: Direction bit one means output, zero input
// R2: Analog select one routes pin to converter
// R3: Output pin driven from data latch
// R4: Output pin reads back latch value
// R5: Input pin keeps driver off
// R6: Input pin write updates latch only
// R7: Input pin reads sampled pin level
// R8: Read-modify-write reloads input bits from pins
// R9: Software loads latch before enabling output
// R10: Analog pin reads as zero
// R11: Reset: direction zeros, analog select ones
// R12: Bits fifteen to eight map pins seven-zero
// R13: Software sets analog or digital input correctly
// R14: Low-power float mode disables drivers, inputs
// R15: Single-cycle byte-wide register access
// ==========================================================
`ifndef EPX_REGS_VH
`define EPX_REGS_VH

// ==========================================================
// Offsets
`define EPX_ADDR_W 8
`define EPX_OFF_DATA 8'h0b
`define EPX_OFF_DIR 8'h1b
`define EPX_OFF_ANA 8'h1f
`define EPX_OFF_MODE 8'h20

// ==========================================================
// Reset values and fields
`define EPX_DIR_RST 8'h00
`define EPX_ANA_RST 8'hff
`define EPX_DATA_RST 8'h00
`define EPX_MODE_RST 8'h00
`define EPX_MODE_FLOAT_BIT 0
`define EPX_MODE_LOWPWR_BIT 1
`define EPX_PIN_LSB 8

`endif

/* rtl/epx_pin_cell.v */
// One port pin: drive control, input blocking and readback
`timescale 1ns/1ps
module epx_pin_cell (
   // Configuration
   input wire dir,
   input wire ana,
   input wire latch,
   input wire park,
   // Pin
   input wire pin_in,
   output wire drv_en,
   output wire drv_val,
   // Readback
   output wire rd_val
);
   wire in_open;

   // R1 R3 R5 R14: drive rule
   assign drv_en = dir & ~ana & ~park;
   assign drv_val = latch;
   // R14 blocked input buffer
   assign in_open = ~park & ~ana;
   // R4 R7 R10: readback select
   assign rd_val = ana ? 1'b0 : (dir ? latch : (pin_in & in_open));
endmodule

/* rtl/epx_port.v */
// Eight-pin general-purpose port with analog select, register slave
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "epx_regs.vh"
module epx_port #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire core_clk,
   input wire rst_n,
   // Register port
   input wire [`EPX_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire reg_rmw,
   output reg [15:0] reg_rdata,
   // Low-power state from the clock controller
   input wire stop_mode,
   // Pins
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_out,
   output reg [WIDTH-1:0] pin_oe,
   // Converter routing
   output reg [WIDTH-1:0] ana_route
);
   // ==========================================================
   // Registers
   reg [WIDTH-1:0] data_r;
   reg [WIDTH-1:0] dir_r;
   reg [WIDTH-1:0] ana_r;
   reg [7:0] mode_r;
   wire [WIDTH-1:0] drv_en;
   wire [WIDTH-1:0] drv_val;
   wire [WIDTH-1:0] rd_bits;
   wire park;
   wire [WIDTH-1:0] wr_bits;
   wire [WIDTH-1:0] data_nxt;
   reg [15:0] rdata_nxt;

   // R14: float only when selected and in a low-power state
   assign park = mode_r[`EPX_MODE_FLOAT_BIT] & (stop_mode | mode_r[`EPX_MODE_LOWPWR_BIT]);

   // ==========================================================
   // Per-pin cells
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         epx_pin_cell u_cell (
            .dir(dir_r[i]),
            .ana(ana_r[i]),
            .latch(data_r[i]),
            .park(park),
            .pin_in(pin_in[i]),
            .drv_en(drv_en[i]),
            .drv_val(drv_val[i]),
            .rd_val(rd_bits[i])
         );
      end
   endgenerate

   // R12: pins sit in upper byte of the bus word
   assign wr_bits = reg_wdata[`EPX_PIN_LSB +: WIDTH];
   // R8: modify cycle stores pin level for input bits
   assign data_nxt = reg_rmw ? ((wr_bits & dir_r) | (rd_bits & ~dir_r)) : wr_bits;

   // ==========================================================
   // Register writes
   // R15 R11: single-cycle writes, reset values
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_r <= `EPX_DATA_RST;
         dir_r <= `EPX_DIR_RST;
         ana_r <= `EPX_ANA_RST;
         mode_r <= `EPX_MODE_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            // R6 latch written regardless of direction
            `EPX_OFF_DATA: data_r <= data_nxt;
            `EPX_OFF_DIR: dir_r <= wr_bits;
            `EPX_OFF_ANA: ana_r <= wr_bits;
            `EPX_OFF_MODE: mode_r <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Read path
   always @* begin
      rdata_nxt = 16'h0000;
      case (reg_addr)
         // R4 R7 R10 readback
         `EPX_OFF_DATA: rdata_nxt[`EPX_PIN_LSB +: WIDTH] = rd_bits;
         `EPX_OFF_DIR: rdata_nxt[`EPX_PIN_LSB +: WIDTH] = dir_r;
         `EPX_OFF_ANA: rdata_nxt[`EPX_PIN_LSB +: WIDTH] = ana_r;
         `EPX_OFF_MODE: rdata_nxt[7:0] = mode_r;
         default: rdata_nxt = 16'h0000;
      endcase
   end

   // ==========================================================
   // Registered outputs
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
         pin_out <= `EPX_DATA_RST;
         pin_oe <= `EPX_DIR_RST;
         ana_route <= `EPX_ANA_RST;
      end else begin
         reg_rdata <= reg_rd ? rdata_nxt : 16'h0000;
         // R3 R5 pin drive
         pin_out <= drv_val;
         pin_oe <= drv_en;
         // R2 converter routing
         ana_route <= ana_r;
      end
   end
endmodule

/* sim/epx_chk.sv */
// Checker for the eight-pin port
`timescale 1ns/1ps
module epx_chk (
   input wire core_clk, input wire rst_n, input wire [7:0] reg_addr,
   input wire [15:0] reg_wdata, input wire reg_wr, input wire reg_rd, input wire reg_rmw,
   input wire [15:0] reg_rdata, input wire stop_mode, input wire [7:0] pin_in,
   input wire [7:0] pin_out, input wire [7:0] pin_oe, input wire [7:0] ana_route);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_dir; reg_wr && reg_addr == 8'h1b ##1 !reg_wr; endsequence
   property p_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_rst; !$past(rst_n) |-> ana_route == 8'hff && pin_oe == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("bad reset state");
   property p_ana; reg_wr && reg_addr == 8'h1f |-> ##2 ana_route == $past(reg_wdata[15:8], 2);
   endproperty
   a_ana: assert property (p_ana) else $error("routing not updated");
   property p_oe_an; (pin_oe & ana_route) == 8'h00; endproperty
   a_oe_an: assert property (p_oe_an) else $error("analog pin driven");
   property p_dir; s_dir ##1 ana_route == 8'h00 && !stop_mode |-> pin_oe == $past(reg_wdata[15:8], 2);
   endproperty
   a_dir: assert property (p_dir) else $error("enable differs from direction");
   property p_hold; reg_wr && !$past(reg_wr) && reg_addr == 8'h0b ##1 !reg_wr |=> $stable(pin_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("data write moved enables");
   property p_an_rd; reg_rd && reg_addr == 8'h0b |=> (reg_rdata[15:8] & $past(ana_route)) == 8'h00;
   endproperty
   a_an_rd: assert property (p_an_rd) else $error("analog bit read nonzero");
   property p_in_rd; reg_rd && reg_addr == 8'h0b && (pin_oe | ana_route) == 8'h00 && !stop_mode
      |=> reg_rdata[15:8] == $past(pin_in); endproperty
   a_in_rd: assert property (p_in_rd) else $error("input read not pin level");
endmodule
bind epx_port epx_chk epx_chk_i (.*);

/* sim/epx_port_tb.sv */
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps
module epx_port_tb;
   reg core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_rmw = 0, stop_mode = 0;
   reg [7:0] reg_addr = 8'h00, pin_in = 8'ha5;
   reg [15:0] reg_wdata = 16'h0000, q;
   wire [15:0] reg_rdata;
   wire [7:0] pin_out, pin_oe, ana_route;
   integer fail_count = 0, tests_run = 0;
   epx_port epx_port_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
      .reg_rdata(reg_rdata), .stop_mode(stop_mode), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .ana_route(ana_route));
   always #4 core_clk = ~core_clk;
   task chk(input [15:0] s, input [15:0] e, input [63:0] n);
      tests_run = tests_run + 1;
      if (s !== e) begin
         fail_count = fail_count + 1;
         $display("BAD %0s exp %h got %h", n, e, s);
      end
   endtask
   task wr(input [7:0] a, input [15:0] d, input m);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_rmw <= m;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rmw <= 1'b0;
   endtask
   task rd(input [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // Outputs lag the register by one more edge
   task settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task t_rst;
      rd(8'h1b); chk(q, 16'h0000, "dir");
      rd(8'h1f); chk(q, 16'hff00, "ana");
      rd(8'h0b); chk(q, 16'h0000, "adc0");
      chk({8'h00, pin_oe}, 16'h0000, "oe0");
   endtask
   task t_io;
      wr(8'h1f, 16'h0000, 1'b0);
      wr(8'h0b, 16'h3c00, 1'b0);
      settle; chk({8'h00, pin_oe}, 16'h0000, "oe_in");
      rd(8'h0b); chk(q, 16'ha500, "pin_rd");
      wr(8'h1b, 16'hff00, 1'b0);
      settle; chk({pin_oe, pin_out}, 16'hff3c, "drive");
      rd(8'h0b); chk(q, 16'h3c00, "latch");
   endtask
   // Low nibble output, high nibble input during the merge
   task t_rmw;
      wr(8'h1b, 16'h0f00, 1'b0);
      wr(8'h0b, 16'h0000, 1'b1);
      wr(8'h1b, 16'hff00, 1'b0);
      settle; chk({8'h00, pin_out}, 16'h00a0, "rmw");
   endtask
   task t_ana;
      wr(8'h1b, 16'hf000, 1'b0);
      wr(8'h1f, 16'h0f00, 1'b0);
      settle; chk({pin_oe, ana_route}, 16'hf00f, "route");
      rd(8'h0b); chk(q, 16'ha000, "anrd");
   endtask
   task t_park;
      wr(8'h20, 16'h0001, 1'b0);
      stop_mode <= 1'b1;
      settle; chk({8'h00, pin_oe}, 16'h0000, "park");
      stop_mode <= 1'b0;
      // Forced low-power bit parks without the stop input
      wr(8'h20, 16'h0003, 1'b0);
      settle; chk({8'h00, pin_oe}, 16'h0000, "lpbit");
      rd(8'h20); chk(q, 16'h0003, "mode");
      wr(8'h20, 16'h0001, 1'b0);
      wr(8'h05, 16'hffff, 1'b0);
      settle; chk({8'h00, pin_oe}, 16'h00f0, "unpark");
      rd(8'h05); chk(q, 16'h0000, "unmap");
   endtask
   task summarize;
      $display("mismatches %0d of %0d checks", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #20000 fail_count = fail_count + 1;
      summarize;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      t_rst; t_io; t_rmw; t_ana; t_park;
      summarize;
   end
endmodule
